// ==== hdl/sbi_top.sv ====
// Overview of operation
// - Two channels, each with own register window
// - Modes: multi-master bus or shift of 1 to 8 bits
// - Bus mode uses only SCL and SDA
// - Shift mode uses SCK, SI and SO
// - Shift clock driven or accepted from peer
// - Offset 0x10: write control two, read status
// - Enable bit 7, cleared after reset
// - Other registers accessible only once enabled
// - Disabled channel stops all but enable and pin-sync logic
// - Disabling keeps every register value
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module sbi_top
  import sbi_pkg::*;
#(
  parameter int HALF_CYC = SBI_HALF_CYC
) (
  // Clock and reset
  input  wire logic                    CLK_I,
  input  wire logic                    NRST_I,
  input  wire logic                    CE_I,
  // Register port
  input  wire logic [SBI_ADDR_W-1:0]   REG_ADDR_I,
  input  wire logic [31:0]             REG_WDATA_I,
  input  wire logic                    REG_WR_I,
  input  wire logic                    REG_RD_I,
  output logic      [31:0]             REG_RDATA_O,
  // Interrupt
  output logic                         IRQ_O,
  // Bus mode pins, open drain
  input  wire logic [SBI_CHANNELS-1:0] SCL_I,
  output logic      [SBI_CHANNELS-1:0] SCL_O,
  output logic      [SBI_CHANNELS-1:0] SCL_OE_O,
  input  wire logic [SBI_CHANNELS-1:0] SDA_I,
  output logic      [SBI_CHANNELS-1:0] SDA_O,
  output logic      [SBI_CHANNELS-1:0] SDA_OE_O,
  // Shift mode pins
  input  wire logic [SBI_CHANNELS-1:0] SCK_I,
  output logic      [SBI_CHANNELS-1:0] SCK_O,
  output logic      [SBI_CHANNELS-1:0] SCK_OE_O,
  input  wire logic [SBI_CHANNELS-1:0] SI_I,
  output logic      [SBI_CHANNELS-1:0] SO_O,
  output logic      [SBI_CHANNELS-1:0] SO_OE_O
);

  logic [7:0]                ofs;
  logic                      ch_sel;
  logic [31:0]               rdata_d;

  logic [SBI_CHANNELS-1:0]   on_q;
  logic [SBI_CHANNELS-1:0]   run;
  logic [SBI_CHANNELS-1:0]   irq_ch;
  logic [7:0]                ctrl1_q   [SBI_CHANNELS];
  logic [7:0]                tx_q      [SBI_CHANNELS];
  logic [7:0]                own_q     [SBI_CHANNELS];
  logic [SBI_RATE_W-1:0]     rate_q    [SBI_CHANNELS];
  logic [SBI_CHANNELS-1:0]   mode_q;
  logic [SBI_CHANNELS-1:0]   sckint_q;
  logic [SBI_CHANNELS-1:0]   stop_q;
  logic [SBI_CHANNELS-1:0]   start_q;
  logic [SBI_INT_W-1:0]      ist_q     [SBI_CHANNELS];
  logic [SBI_INT_W-1:0]      imask_q   [SBI_CHANNELS];
  logic [7:0]                rx        [SBI_CHANNELS];
  logic [SBI_CHANNELS-1:0]   busy;
  logic [SBI_CHANNELS-1:0]   ack_rcv;
  logic [SBI_CHANNELS-1:0]   bus_act;
  logic [SBI_CHANNELS-1:0]   done;
  logic [SBI_CHANNELS-1:0]   arb;
  sbi_pin_out_s              pins_out  [SBI_CHANNELS];

  assign ofs    = REG_ADDR_I[7:0];
  assign ch_sel = REG_ADDR_I[SBI_CHAN_BIT];

  for (genvar c = 0; c < SBI_CHANNELS; c++) begin : g_chan
    logic          hit;
    logic          wr_on;
    logic          wr_reg;
    logic [3:0]    sync1_q;
    logic [3:0]    sync2_q;
    logic [SBI_INT_W-1:0] ev;
    logic [SBI_INT_W-1:0] clr;
    logic [2:0]    bpt;
    sbi_pin_in_s   pins_in;
    sbi_cfg_s      cfg;

    assign hit    = (ch_sel == 1'(c));
    assign wr_on  = REG_WR_I && hit && (ofs == SBI_OFS_ENABLE);
    assign wr_reg = REG_WR_I && hit && on_q[c];
    // Everything but the enable register and the pin synchronisers sleeps while the channel is off
    assign run[c] = CE_I && on_q[c];

    always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        on_q[c] <= 1'b0;
      end else if (CE_I && wr_on) begin
        on_q[c] <= REG_WDATA_I[SBI_ON_BIT];
      end
    end

    // Two-stage capture of every pin input
    always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        sync1_q <= 4'hF;
        sync2_q <= 4'hF;
      end else if (CE_I) begin
        sync1_q <= {SCL_I[c], SDA_I[c], SCK_I[c], SI_I[c]};
        sync2_q <= sync1_q;
      end
    end
    assign pins_in = sbi_pin_in_s'(sync2_q);

    // Off state holds register contents; no reset on disable
    always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        ctrl1_q[c] <= SBI_CTRL1_RST;
        tx_q[c]    <= 8'h00;
        own_q[c]   <= 8'h00;
        rate_q[c]  <= '0;
      end else if (CE_I && wr_reg) begin
        unique case (ofs)
          SBI_OFS_CTRL1:   ctrl1_q[c] <= REG_WDATA_I[7:0];
          SBI_OFS_DATA:    tx_q[c]    <= REG_WDATA_I[7:0];
          SBI_OFS_OWNADDR: own_q[c]   <= REG_WDATA_I[7:0];
          SBI_OFS_BITRATE: rate_q[c]  <= REG_WDATA_I[SBI_RATE_W-1:0];
          default: ;
        endcase
      end
    end

    // Write side of the shared offset; status is never touched
    always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        mode_q[c]   <= 1'b0;
        sckint_q[c] <= 1'b0;
        stop_q[c]   <= 1'b0;
      end else if (CE_I && wr_reg && ofs == SBI_OFS_CTRL2_ST) begin
        mode_q[c]   <= REG_WDATA_I[SBI_MODE_BIT];
        sckint_q[c] <= REG_WDATA_I[SBI_SCKOUT_BIT];
        stop_q[c]   <= REG_WDATA_I[SBI_STOP_BIT];
      end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        start_q[c] <= 1'b0;
      end else if (CE_I) begin
        start_q[c] <= wr_reg && ofs == SBI_OFS_CTRL2_ST && REG_WDATA_I[SBI_START_BIT];
      end
    end

    // Sticky events; a new event beats a same-cycle clear
    assign ev  = {arb[c], done[c]} & {SBI_INT_W{run[c]}};
    assign clr = (wr_reg && ofs == SBI_OFS_INT_STAT) ? REG_WDATA_I[SBI_INT_W-1:0] : '0;

    always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        ist_q[c]   <= '0;
        imask_q[c] <= '0;
      end else if (CE_I) begin
        ist_q[c] <= (ist_q[c] & ~clr) | ev;
        if (wr_reg && ofs == SBI_OFS_INT_MASK) begin
          imask_q[c] <= REG_WDATA_I[SBI_INT_W-1:0];
        end
      end
    end
    assign irq_ch[c] = |(ist_q[c] & imask_q[c]);

    assign bpt              = ctrl1_q[c][SBI_BPT_LSB +: 3];
    assign cfg.i2c_mode     = mode_q[c];
    assign cfg.sck_internal = sckint_q[c];
    assign cfg.stop_req     = stop_q[c];
    assign cfg.ack_en       = ctrl1_q[c][SBI_ACK_BIT];
    assign cfg.nbits        = (bpt == 3'h0) ? 4'(SBI_BYTE_BITS) : {1'b0, bpt};
    assign cfg.rate_exp     = rate_q[c];
    assign cfg.tx           = tx_q[c];

    sbi_engine #(
      .HALF_CYC (HALF_CYC)
    ) u_engine (
      .clk_i     (CLK_I),
      .rst_ni    (NRST_I),
      .run_i     (run[c]),
      .start_i   (start_q[c]),
      .cfg_i     (cfg),
      .pins_i    (pins_in),
      .pins_o    (pins_out[c]),
      .rx_o      (rx[c]),
      .done_o    (done[c]),
      .arb_o     (arb[c]),
      .ack_o     (ack_rcv[c]),
      .busy_o    (busy[c]),
      .bus_act_o (bus_act[c])
    );

    // Engine pin outputs are flops; open-drain data levels stay low
    assign SCL_O[c]    = pins_out[c].scl_o;
    assign SCL_OE_O[c] = pins_out[c].scl_oe;
    assign SDA_O[c]    = pins_out[c].sda_o;
    assign SDA_OE_O[c] = pins_out[c].sda_oe;
    assign SCK_O[c]    = pins_out[c].sck_o;
    assign SCK_OE_O[c] = pins_out[c].sck_oe;
    assign SO_O[c]     = pins_out[c].so_o;
    assign SO_OE_O[c]  = pins_out[c].so_oe;
  end

  // Read mux; disabled channels answer zero outside the enable register
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (ofs == SBI_OFS_ENABLE) begin
      rdata_d[SBI_ON_BIT] = on_q[ch_sel];
    end else if (on_q[ch_sel]) begin
      unique case (ofs)
        SBI_OFS_CTRL1:    rdata_d[7:0] = ctrl1_q[ch_sel];
        SBI_OFS_DATA:     rdata_d[7:0] = rx[ch_sel];
        SBI_OFS_OWNADDR:  rdata_d[7:0] = own_q[ch_sel];
        SBI_OFS_CTRL2_ST: begin
          rdata_d[SBI_ST_BUSY_BIT] = busy[ch_sel];
          rdata_d[SBI_ST_ACK_BIT]  = ack_rcv[ch_sel];
          rdata_d[SBI_ST_BUS_BIT]  = bus_act[ch_sel];
          rdata_d[SBI_ST_MODE_BIT] = mode_q[ch_sel];
        end
        SBI_OFS_BITRATE:  rdata_d[SBI_RATE_W-1:0] = rate_q[ch_sel];
        SBI_OFS_INT_STAT: rdata_d[SBI_INT_W-1:0] = ist_q[ch_sel];
        SBI_OFS_INT_MASK: rdata_d[SBI_INT_W-1:0] = imask_q[ch_sel];
        default:          rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      REG_RDATA_O <= 32'h0000_0000;
    end else if (CE_I) begin
      REG_RDATA_O <= REG_RD_I ? rdata_d : 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      IRQ_O <= 1'b0;
    end else if (CE_I) begin
      IRQ_O <= |irq_ch;
    end
  end

endmodule

// ==== hdl/sbi_pkg.sv ====
package sbi_pkg;

  localparam int SBI_CHANNELS = 2;
  localparam int SBI_ADDR_W   = 9;
  localparam int SBI_CHAN_BIT = 8;

  // Word offsets inside one channel window
  localparam logic [7:0] SBI_OFS_ENABLE   = 8'h00;
  localparam logic [7:0] SBI_OFS_CTRL1    = 8'h04;
  localparam logic [7:0] SBI_OFS_DATA     = 8'h08;
  localparam logic [7:0] SBI_OFS_OWNADDR  = 8'h0C;
  localparam logic [7:0] SBI_OFS_CTRL2_ST = 8'h10;
  localparam logic [7:0] SBI_OFS_BITRATE  = 8'h14;
  localparam logic [7:0] SBI_OFS_INT_STAT = 8'h18;
  localparam logic [7:0] SBI_OFS_INT_MASK = 8'h1C;

  // channel_enable_control
  localparam int SBI_ON_BIT = 7;
  // transfer_control_one
  localparam int SBI_BPT_LSB = 5;
  localparam int SBI_ACK_BIT = 4;
  localparam logic [7:0] SBI_CTRL1_RST = 8'h00;
  // transfer_control_two (write side)
  localparam int SBI_MODE_BIT   = 3;
  localparam int SBI_START_BIT  = 4;
  localparam int SBI_STOP_BIT   = 5;
  localparam int SBI_SCKOUT_BIT = 6;
  // channel_status (read side)
  localparam int SBI_ST_BUSY_BIT = 0;
  localparam int SBI_ST_ACK_BIT  = 1;
  localparam int SBI_ST_BUS_BIT  = 2;
  localparam int SBI_ST_MODE_BIT = 3;
  // Interrupt status and mask
  localparam int SBI_INT_W        = 2;
  localparam int SBI_INT_DONE_BIT = 0;
  localparam int SBI_INT_ARB_BIT  = 1;
  // bit_rate_control
  localparam int SBI_RATE_W = 3;

  // Timing: base half period of the bit clock
  localparam int SBI_CLK_MHZ  = 200;
  localparam int SBI_HALF_NS  = 250;
  localparam int SBI_HALF_CYC = (SBI_HALF_NS * SBI_CLK_MHZ) / 1000;
  localparam int SBI_BYTE_BITS = 8;

  typedef enum {
    SBI_IDLE, SBI_START, SBI_LOW, SBI_HIGH, SBI_STOP_A, SBI_STOP_B, SBI_EXT
  } sbi_state_e;

  typedef struct packed {
    logic                  i2c_mode;
    logic                  sck_internal;
    logic                  stop_req;
    logic                  ack_en;
    logic [3:0]            nbits;
    logic [SBI_RATE_W-1:0] rate_exp;
    logic [7:0]            tx;
  } sbi_cfg_s;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sck;
    logic si;
  } sbi_pin_in_s;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
    logic sck_o;
    logic sck_oe;
    logic so_o;
    logic so_oe;
  } sbi_pin_out_s;

  localparam sbi_pin_out_s SBI_PINS_IDLE = '{
    scl_o: 1'b0, scl_oe: 1'b0, sda_o: 1'b0, sda_oe: 1'b0,
    sck_o: 1'b1, sck_oe: 1'b0, so_o: 1'b0, so_oe: 1'b0};

endpackage

// ==== hdl/sbi_engine.sv ====
`timescale 1ns/1ps
module sbi_engine
  import sbi_pkg::*;
#(
  parameter int HALF_CYC = SBI_HALF_CYC
) (
  // Clock, reset, gating
  input  wire logic   clk_i,
  input  wire logic   rst_ni,
  input  wire logic   run_i,
  // Control
  input  wire logic   start_i,
  input  sbi_cfg_s    cfg_i,
  // Pins (already synchronised)
  input  sbi_pin_in_s pins_i,
  output sbi_pin_out_s pins_o,
  // Results
  output logic [7:0]  rx_o,
  output logic        done_o,
  output logic        arb_o,
  output logic        ack_o,
  output logic        busy_o,
  output logic        bus_act_o
);

  sbi_state_e  st_q;
  logic [15:0] tick_q;
  logic [15:0] half;
  logic        half_done;
  logic [3:0]  cnt_q;
  logic [7:0]  sh_q;
  logic        ack_ph_q;
  logic        sck_d_q;
  logic        sck_rise;
  logic        last_bit;
  logic        fin;
  logic        wait_scl;

  assign half      = 16'(HALF_CYC) << cfg_i.rate_exp;
  assign half_done = (tick_q >= half - 16'h0001);
  assign last_bit  = (cnt_q == cfg_i.nbits - 4'h1);
  assign fin       = ack_ph_q || (last_bit && !(cfg_i.i2c_mode && cfg_i.ack_en));
  assign sck_rise  = pins_i.sck && !sck_d_q;
  assign rx_o      = sh_q;
  assign busy_o    = (st_q != SBI_IDLE);
  // High phases wait for the wire itself: stretching and wired clock sync
  assign wait_scl  = cfg_i.i2c_mode && !pins_i.scl && (st_q == SBI_HIGH || st_q == SBI_STOP_B);

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      tick_q <= 16'h0000;
    end else if (run_i) begin
      if (st_q == SBI_IDLE || st_q == SBI_EXT || half_done || wait_scl) begin
        tick_q <= 16'h0000;
      end else begin
        tick_q <= tick_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      sck_d_q <= 1'b1;
    end else if (run_i) begin
      sck_d_q <= pins_i.sck;
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      st_q      <= SBI_IDLE;
      pins_o    <= SBI_PINS_IDLE;
      sh_q      <= 8'h00;
      cnt_q     <= 4'h0;
      ack_ph_q  <= 1'b0;
      done_o    <= 1'b0;
      arb_o     <= 1'b0;
      ack_o     <= 1'b0;
      bus_act_o <= 1'b0;
    end else if (run_i) begin
      done_o <= 1'b0;
      arb_o  <= 1'b0;
      unique case (st_q)
        SBI_IDLE: if (start_i) begin
          sh_q     <= cfg_i.tx;
          cnt_q    <= 4'h0;
          ack_ph_q <= 1'b0;
          if (cfg_i.i2c_mode) begin
            bus_act_o <= 1'b1;
            if (bus_act_o) begin
              pins_o.sda_oe <= ~cfg_i.tx[7];
              st_q          <= SBI_LOW;
            end else begin
              pins_o.sda_oe <= 1'b1;
              st_q          <= SBI_START;
            end
          end else begin
            pins_o.so_o  <= cfg_i.tx[7];
            pins_o.so_oe <= 1'b1;
            if (cfg_i.sck_internal) begin
              pins_o.sck_oe <= 1'b1;
              pins_o.sck_o  <= 1'b0;
              st_q          <= SBI_LOW;
            end else begin
              pins_o.sck_oe <= 1'b0;
              st_q          <= SBI_EXT;
            end
          end
        end
        SBI_START: if (half_done) begin
          pins_o.scl_oe <= 1'b1;
          pins_o.sda_oe <= ~sh_q[7];
          st_q          <= SBI_LOW;
        end
        SBI_LOW: if (half_done) begin
          if (cfg_i.i2c_mode) begin
            pins_o.scl_oe <= 1'b0;
          end else begin
            pins_o.sck_o <= 1'b1;
          end
          st_q <= SBI_HIGH;
        end
        SBI_HIGH: if (half_done) begin
          if (cfg_i.i2c_mode && !ack_ph_q && !pins_o.sda_oe && !pins_i.sda) begin
            // Another master won the wired-AND: let go of both lines
            pins_o.scl_oe <= 1'b0;
            pins_o.sda_oe <= 1'b0;
            bus_act_o     <= 1'b0;
            arb_o         <= 1'b1;
            st_q          <= SBI_IDLE;
          end else begin
            if (ack_ph_q) begin
              ack_o <= ~pins_i.sda;
            end else begin
              sh_q  <= {sh_q[6:0], cfg_i.i2c_mode ? pins_i.sda : pins_i.si};
              cnt_q <= cnt_q + 4'h1;
            end
            if (cfg_i.i2c_mode) begin
              pins_o.scl_oe <= 1'b1;
            end else begin
              pins_o.sck_o <= fin;
            end
            if (!fin) begin
              if (last_bit) begin
                pins_o.sda_oe <= 1'b0;
                ack_ph_q      <= 1'b1;
              end else if (cfg_i.i2c_mode) begin
                pins_o.sda_oe <= ~sh_q[6];
              end else begin
                pins_o.so_o <= sh_q[6];
              end
              st_q <= SBI_LOW;
            end else if (cfg_i.i2c_mode && cfg_i.stop_req) begin
              pins_o.sda_oe <= 1'b1;
              st_q          <= SBI_STOP_A;
            end else begin
              pins_o.sck_oe <= 1'b0;
              pins_o.so_oe  <= 1'b0;
              done_o        <= 1'b1;
              st_q          <= SBI_IDLE;
            end
          end
        end
        SBI_STOP_A: if (half_done) begin
          pins_o.scl_oe <= 1'b0;
          st_q          <= SBI_STOP_B;
        end
        SBI_STOP_B: if (half_done) begin
          pins_o.sda_oe <= 1'b0;
          bus_act_o     <= 1'b0;
          done_o        <= 1'b1;
          st_q          <= SBI_IDLE;
        end
        SBI_EXT: if (sck_rise) begin
          sh_q        <= {sh_q[6:0], pins_i.si};
          cnt_q       <= cnt_q + 4'h1;
          pins_o.so_o <= sh_q[6];
          if (last_bit) begin
            pins_o.so_oe <= 1'b0;
            done_o       <= 1'b1;
            st_q         <= SBI_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// ==== testbench/sbi_checker.sv ====
`timescale 1ns/1ps
module sbi_checker
  import sbi_pkg::*;
(
  // Clock and reset
  input  wire logic                    CLK_I,
  input  wire logic                    NRST_I,
  // Register port
  input  wire logic [SBI_ADDR_W-1:0]   REG_ADDR_I,
  input  wire logic [31:0]             REG_WDATA_I,
  input  wire logic                    REG_WR_I,
  input  wire logic                    REG_RD_I,
  input  wire logic [31:0]             REG_RDATA_O,
  // Pins
  input  wire logic [SBI_CHANNELS-1:0] SCL_O,
  input  wire logic [SBI_CHANNELS-1:0] SDA_O,
  input  wire logic [SBI_CHANNELS-1:0] SCL_OE_O,
  input  wire logic [SBI_CHANNELS-1:0] SDA_OE_O,
  input  wire logic [SBI_CHANNELS-1:0] SCK_O,
  input  wire logic [SBI_CHANNELS-1:0] SCK_OE_O,
  input  wire logic [SBI_CHANNELS-1:0] SO_O,
  input  wire logic [SBI_CHANNELS-1:0] SO_OE_O
);
  logic [SBI_CHANNELS-1:0] en_q;
  logic [SBI_CHANNELS-1:0] mode_q;
  logic [SBI_CHANNELS-1:0] sckint_q;
  logic                    rd_q;
  logic                    rd_en_q;
  logic                    rd_mode_q;
  logic [7:0]              rd_ofs_q;
  logic                    ch;

  assign ch = REG_ADDR_I[SBI_CHAN_BIT];

  // Shadow of the enable bit and of the mode fields, written only while enabled
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      en_q     <= '0;
      mode_q   <= '0;
      sckint_q <= '0;
    end else if (REG_WR_I && REG_ADDR_I[7:0] == SBI_OFS_ENABLE) begin
      en_q[ch] <= REG_WDATA_I[SBI_ON_BIT];
    end else if (REG_WR_I && REG_ADDR_I[7:0] == SBI_OFS_CTRL2_ST && en_q[ch]) begin
      mode_q[ch]   <= REG_WDATA_I[SBI_MODE_BIT];
      sckint_q[ch] <= REG_WDATA_I[SBI_SCKOUT_BIT];
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rd_q      <= 1'b0;
      rd_en_q   <= 1'b0;
      rd_mode_q <= 1'b0;
      rd_ofs_q  <= 8'h00;
    end else begin
      rd_q      <= REG_RD_I;
      rd_en_q   <= en_q[ch];
      rd_mode_q <= mode_q[ch];
      rd_ofs_q  <= REG_ADDR_I[7:0];
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  property p_scl_od;
    SCL_O == 2'h0;
  endproperty
  a_scl_od: assert property (p_scl_od)
    else $error("clock line driven high");
  property p_sda_od;
    SDA_O == 2'h0;
  endproperty
  a_sda_od: assert property (p_sda_od)
    else $error("data line driven high");
  property p_en_read;
    rd_q && rd_ofs_q == SBI_OFS_ENABLE |-> REG_RDATA_O == {24'h000000, rd_en_q, 7'h00};
  endproperty
  a_en_read: assert property (p_en_read)
    else $error("enable register read wrong");
  property p_refused;
    rd_q && !rd_en_q && rd_ofs_q != SBI_OFS_ENABLE |-> REG_RDATA_O == 32'h00000000;
  endproperty
  a_refused: assert property (p_refused)
    else $error("disabled channel returned data");
  property p_status;
    rd_q && rd_en_q && rd_ofs_q == SBI_OFS_CTRL2_ST
      |-> REG_RDATA_O[31:4] == 28'h0000000 && REG_RDATA_O[SBI_ST_MODE_BIT] == rd_mode_q;
  endproperty
  a_status: assert property (p_status)
    else $error("status read does not match mode");
  property p_frozen;
    !en_q[0] && $past(!en_q[0]) && $past(!en_q[0], 2)
      |-> $stable({SCL_OE_O[0], SDA_OE_O[0], SCK_O[0], SCK_OE_O[0], SO_O[0], SO_OE_O[0]});
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("pins moved while channel off");
  property p_bus_pins;
    mode_q[0] |-> !SCK_OE_O[0] && !SO_OE_O[0];
  endproperty
  a_bus_pins: assert property (p_bus_pins)
    else $error("shift pins driven in bus mode");
  property p_shift_pins;
    !mode_q[0] |-> !SCL_OE_O[0] && !SDA_OE_O[0];
  endproperty
  a_shift_pins: assert property (p_shift_pins)
    else $error("bus lines pulled in shift mode");
  property p_sck_dir;
    !sckint_q[0] |-> !SCK_OE_O[0];
  endproperty
  a_sck_dir: assert property (p_sck_dir)
    else $error("shift clock driven while external");
endmodule

bind sbi_top sbi_checker sbi_checker_i (
  .CLK_I(CLK_I), .NRST_I(NRST_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .SCL_O(SCL_O), .SDA_O(SDA_O), .SCL_OE_O(SCL_OE_O), .SDA_OE_O(SDA_OE_O),
  .SCK_O(SCK_O), .SCK_OE_O(SCK_OE_O), .SO_O(SO_O), .SO_OE_O(SO_OE_O));

// ==== testbench/sbi_peer.sv ====
`timescale 1ns/1ps
module sbi_peer (
  // Bus mode, open drain with pull-ups
  input  wire logic       scl_oe_i,
  input  wire logic       sda_oe_i,
  input  wire logic       hold_sda_i,
  output logic            scl_o,
  output logic            sda_o,
  output logic [7:0]      i2c_byte_o,
  // Shift mode
  input  wire logic       sck_i,
  input  wire logic       sck_oe_i,
  input  wire logic       so_i,
  input  wire logic       so_oe_i,
  input  wire logic       ext_go_i,
  input  wire logic [7:0] si_byte_i,
  output logic            sck_o,
  output logic            si_o,
  output logic [7:0]      so_byte_o
);
  logic       ack_q = 1'b0;
  logic       sck_q = 1'b1;
  logic [2:0] fall_q = 3'h0;
  int         bit_cnt = 0;

  // Wired-AND of all parties on each bus line
  assign scl_o = ~scl_oe_i;
  assign sda_o = ~(sda_oe_i | ack_q | hold_sda_i);
  assign sck_o = sck_oe_i ? sck_i : sck_q;

  initial begin
    si_o       = 1'b0;
    i2c_byte_o = 8'h00;
    so_byte_o  = 8'h00;
  end
  // Start condition restarts the bit count
  always @(negedge sda_o) begin
    if (scl_o) begin
      bit_cnt = 0;
    end
  end
  always @(posedge scl_o) begin
    if (bit_cnt < 8) begin
      i2c_byte_o = {i2c_byte_o[6:0], sda_o};
    end
    bit_cnt = bit_cnt + 1;
  end
  // Acknowledge through the ninth clock
  always @(negedge scl_o) begin
    ack_q = (bit_cnt == 8);
  end
  always @(posedge sck_o) begin
    so_byte_o = {so_byte_o[6:0], so_i};
  end
  // Eight falls per word, so the counter wraps at the end of each word
  always @(negedge sck_o) begin
    si_o   = si_byte_i[3'h7 - fall_q];
    fall_q = fall_q + 3'h1;
  end
  // Between words the line shows the inverse of its last bit
  always @(negedge so_oe_i) begin
    si_o = ~si_o;
  end
  // External shift clock, 48 ns, standing high outside words
  always @(posedge ext_go_i) begin
    repeat (8) begin
      #24;
      sck_q = 1'b0;
      #24;
      sck_q = 1'b1;
    end
  end
endmodule

// ==== testbench/test_sbi_top.sv ====
`timescale 1ns/1ps
module test_sbi_top;
  logic                              clk;
  logic                              nrst_n;
  logic [sbi_pkg::SBI_ADDR_W-1:0]    addr;
  logic [31:0]                       wdata;
  logic                              wr;
  logic                              rd;
  logic [31:0]                       rdata;
  logic                              irq;
  logic [1:0]                        scl_out, sda_out, scl_oe, sda_oe, sck_o, sck_oe, so_o, so_oe;
  logic                              scl_w, sda_w, sck_w, si_w, hold_sda, ext_go;
  logic [7:0]                        si_byte, i2c_byte, so_byte;
  int                                error_cnt = 0;
  int                                comparisons = 0;
  int                                cyc = 0;

  sbi_top #(.HALF_CYC(4)) sbi_top_i (
    .CLK_I(clk), .NRST_I(nrst_n), .CE_I(1'b1),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .IRQ_O(irq),
    .SCL_I({1'b1, scl_w}), .SCL_O(scl_out), .SCL_OE_O(scl_oe),
    .SDA_I({1'b1, sda_w}), .SDA_O(sda_out), .SDA_OE_O(sda_oe),
    .SCK_I({1'b1, sck_w}), .SCK_O(sck_o), .SCK_OE_O(sck_oe),
    .SI_I({1'b0, si_w}), .SO_O(so_o), .SO_OE_O(so_oe));

  sbi_peer sbi_peer_i (
    .scl_oe_i(scl_oe[0]), .sda_oe_i(sda_oe[0]), .hold_sda_i(hold_sda), .scl_o(scl_w),
    .sda_o(sda_w), .i2c_byte_o(i2c_byte), .sck_i(sck_o[0]), .sck_oe_i(sck_oe[0]),
    .so_i(so_o[0]), .so_oe_i(so_oe[0]), .ext_go_i(ext_go), .si_byte_i(si_byte),
    .sck_o(sck_w), .si_o(si_w), .so_byte_o(so_byte));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [8:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask
  task automatic wait_int(input logic [31:0] m);
    logic [31:0] v;
    int          n;
    n = 0;
    v = 32'h00000000;
    while ((v & m) === 32'h00000000 && n < 1000) begin
      rd_reg(9'h018, v);
      n++;
    end
    chk(v & m, m);
  endtask
  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge clk);
    #1;
    chk(32'(irq), 32'(exp));
  endtask

  initial begin
    nrst_n   = 1'b0;
    addr     = 9'h000;
    wdata    = 32'h00000000;
    wr       = 1'b0;
    rd       = 1'b0;
    hold_sda = 1'b0;
    ext_go   = 1'b0;
    si_byte  = 8'h3C;
    repeat (12) @(posedge clk);
    nrst_n <= 1'b1;
    // Registers before and after the channel is switched on
    rd_chk(9'h000, 32'h00000000);
    wr_reg(9'h00C, 32'h0000005A);
    rd_chk(9'h00C, 32'h00000000);
    wr_reg(9'h000, 32'h00000080);
    rd_chk(9'h000, 32'h00000080);
    wr_reg(9'h00C, 32'h0000005A);
    rd_chk(9'h00C, 32'h0000005A);
    rd_chk(9'h10C, 32'h00000000);
    wr_reg(9'h100, 32'h00000080);
    wr_reg(9'h10C, 32'h00000033);
    rd_chk(9'h10C, 32'h00000033);
    rd_chk(9'h00C, 32'h0000005A);
    // Shared offset: write side control, read side status
    wr_reg(9'h004, 32'h00000010);
    wr_reg(9'h010, 32'h00000008);
    rd_chk(9'h010, 32'h00000008);
    rd_chk(9'h004, 32'h00000010);
    rd_chk(9'h040, 32'h00000000);
    // Switching off and on again keeps contents
    wr_reg(9'h000, 32'h00000000);
    rd_chk(9'h00C, 32'h00000000);
    wr_reg(9'h000, 32'h00000080);
    rd_chk(9'h00C, 32'h0000005A);
    rd_chk(9'h004, 32'h00000010);
    // Bus mode byte with acknowledge and stop
    wr_reg(9'h01C, 32'h00000003);
    wr_reg(9'h008, 32'h000000A5);
    wr_reg(9'h010, 32'h00000038);
    wait_int(32'h00000001);
    chk(32'(i2c_byte), 32'h000000A5);
    rd_chk(9'h010, 32'h0000000A);
    irq_chk(1'b1);
    wr_reg(9'h018, 32'h00000001);
    irq_chk(1'b0);
    // Another master holds the data line low
    hold_sda = 1'b1;
    wr_reg(9'h008, 32'h000000FF);
    wr_reg(9'h010, 32'h00000038);
    wait_int(32'h00000002);
    rd_chk(9'h018, 32'h00000002);
    hold_sda = 1'b0;
    wr_reg(9'h018, 32'h00000002);
    // Shift mode, internal clock, done event masked
    wr_reg(9'h01C, 32'h00000000);
    wr_reg(9'h010, 32'h00000000);
    wr_reg(9'h008, 32'h000000C3);
    wr_reg(9'h010, 32'h00000050);
    wait_int(32'h00000001);
    chk(32'(so_byte), 32'h000000C3);
    rd_chk(9'h008, 32'h0000003C);
    irq_chk(1'b0);
    wr_reg(9'h018, 32'h00000001);
    // Shift mode, clock from the peer
    si_byte = 8'h69;
    wr_reg(9'h008, 32'h00000096);
    wr_reg(9'h010, 32'h00000010);
    repeat (6) @(posedge clk);
    ext_go <= 1'b1;
    @(posedge clk);
    ext_go <= 1'b0;
    wait_int(32'h00000001);
    chk(32'(so_byte), 32'h00000096);
    rd_chk(9'h008, 32'h00000069);
    end_of_test();
  end
endmodule
